// ---- hw/mbf_pkg.sv ----
/*
 mbf_pkg: widths, address map, wait-state figures, one-hot types and
 shared address-decode functions for the memory-bus fabric; wait selection is in mbf_fabric.
 assumes 16-bit word addressing as presented by the CPU address buses.
*/
package mbf_pkg;

   // bus widths
   localparam int PAB_W = 22;
   localparam int DAB_W = 32;
   localparam int DB_W  = 32;
   localparam int PB_AW = 16;
   localparam int WS_W  = 5;

   // address map, word addresses
   localparam logic [31:0] SCR_LO   = 32'h0000_0000;
   localparam logic [31:0] SCR_HI   = 32'h0000_07FF;
   localparam logic [31:0] PF0_LO   = 32'h0000_0800;
   localparam logic [31:0] PF0_HI   = 32'h0000_0FFF;
   localparam logic [31:0] PF1_LO   = 32'h0000_6000;
   localparam logic [31:0] PF1_HI   = 32'h0000_6FFF;
   localparam logic [31:0] PF2_LO   = 32'h0000_7000;
   localparam logic [31:0] PF2_HI   = 32'h0000_7FFF;
   localparam logic [31:0] LOW_LO   = 32'h0000_8000;
   localparam logic [31:0] LOW_HI   = 32'h0000_9FFF;
   localparam logic [31:0] UPR_LO   = 32'h0000_A000;
   localparam logic [31:0] UPR_HI   = 32'h0000_BFFF;
   localparam logic [31:0] OTP_LO   = 32'h003D_7800;
   localparam logic [31:0] OTP_HI   = 32'h003D_7BFF;
   localparam logic [31:0] FLASH_LO = 32'h003D_8000;
   localparam logic [31:0] FLASH_HI = 32'h003F_7FFF;
   localparam logic [31:0] PWD_LO   = 32'h003F_7FF8;
   localparam logic [31:0] PWD_HI   = 32'h003F_7FFF;
   localparam logic [31:0] BROM_LO  = 32'h003F_F000;
   localparam logic [31:0] BROM_HI  = 32'h003F_FFFF;

   // wait-state figures
   localparam logic [WS_W-1:0] WS_ZERO    = 5'h00;
   localparam logic [WS_W-1:0] WS_BROM    = 5'h01;
   localparam logic [WS_W-1:0] WS_PF_RD   = 5'h02;
   localparam logic [WS_W-1:0] WS_PF1_B2B = 5'h01;
   localparam logic [WS_W-1:0] WS_PWD     = 5'h10;
   localparam logic [WS_W-1:0] WS_OTP_MIN = 5'h01;

   // target ports
   localparam int TGT_MEM = 0;
   localparam int TGT_PER = 1;

   typedef enum logic [10:0] {
      RG_SCR   = 11'h001,
      RG_LOW   = 11'h002,
      RG_UPR   = 11'h004,
      RG_PF0   = 11'h008,
      RG_PF1   = 11'h010,
      RG_PF2   = 11'h020,
      RG_OTP   = 11'h040,
      RG_FLASH = 11'h080,
      RG_PWD   = 11'h100,
      RG_BROM  = 11'h200,
      RG_NONE  = 11'h400
   } mbf_region_t;

   typedef enum logic [2:0] {
      SRC_WR = 3'h1,
      SRC_RD = 3'h2,
      SRC_PG = 3'h4
   } mbf_src_t;

   typedef struct packed {
      logic             valid;
      logic             fetch;
      logic [PAB_W-1:0] addr;
   } mbf_pgreq_t;

   typedef struct packed {
      logic             valid;
      logic             wide;
      logic [DAB_W-1:0] addr;
   } mbf_rdreq_t;

   typedef struct packed {
      logic             valid;
      logic             prog;
      logic             wide;
      logic [DAB_W-1:0] addr;
      logic [DB_W-1:0]  data;
   } mbf_wrreq_t;

   typedef struct packed {
      logic             valid;
      logic             we;
      logic             wide;
      logic [PAB_W-1:0] addr;
      logic [DB_W-1:0]  wdata;
   } mbf_mem_t;

   typedef struct packed {
      logic             valid;
      logic             we;
      logic             wide;
      logic [PB_AW-1:0] addr;
      logic [DB_W-1:0]  wdata;
   } mbf_pbus_t;

   function automatic logic mbf_in(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
      mbf_in = (a >= lo) && (a <= hi);
   endfunction : mbf_in

   // peripheral frames answer data space only
   function automatic mbf_region_t mbf_decode(input logic [31:0] a, input logic dspace);
      mbf_decode = RG_NONE;
      if (mbf_in(a, SCR_LO, SCR_HI)) mbf_decode = RG_SCR;
      else if (mbf_in(a, LOW_LO, LOW_HI)) mbf_decode = RG_LOW;
      else if (mbf_in(a, UPR_LO, UPR_HI)) mbf_decode = RG_UPR;
      else if (mbf_in(a, PF0_LO, PF0_HI) && dspace) mbf_decode = RG_PF0;
      else if (mbf_in(a, PF1_LO, PF1_HI) && dspace) mbf_decode = RG_PF1;
      else if (mbf_in(a, PF2_LO, PF2_HI) && dspace) mbf_decode = RG_PF2;
      else if (mbf_in(a, OTP_LO, OTP_HI)) mbf_decode = RG_OTP;
      else if (mbf_in(a, PWD_LO, PWD_HI)) mbf_decode = RG_PWD;
      else if (mbf_in(a, FLASH_LO, FLASH_HI)) mbf_decode = RG_FLASH;
      else if (mbf_in(a, BROM_LO, BROM_HI)) mbf_decode = RG_BROM;
   endfunction : mbf_decode

endpackage : mbf_pkg

// ---- hw/mbf_slot.sv ----
/*
 mbf_slot: holds one target access through its wait states.
 assumes start only while idle or in the done cycle; hold comes
 from same-clock logic.
*/
`timescale 1ns/10ps
module mbf_slot #(
   parameter int WS_W = 5
) (
   // clock and reset
   input  wire logic            core_clk,
   input  wire logic            resetn,
   // control
   input  wire logic            start,
   input  wire logic [WS_W-1:0] waits,
   input  wire logic            hold,
   // status
   output logic                 done,
   output logic                 idle
);
   typedef enum logic [1:0] {
      SL_IDLE = 2'h1,
      SL_BUSY = 2'h2
   } mbf_slot_st_t;

   typedef struct packed {
      mbf_slot_st_t    st;
      logic [WS_W-1:0] cnt;
   } mbf_slot_t;

   mbf_slot_t r;
   mbf_slot_t n;

   assign idle = (r.st == SL_IDLE);
   assign done = (r.st == SL_BUSY) && (r.cnt == '0) && !hold;

   always_comb begin
      n = r;
      unique case (r.st)
         SL_IDLE: begin
            if (start) begin
               n.st  = SL_BUSY;
               n.cnt = waits;
            end
         end
         SL_BUSY: begin
            if (r.cnt != '0) begin
               n.cnt = r.cnt - 1'b1;
            end else if (!hold) begin
               n.st  = start ? SL_BUSY : SL_IDLE;
               n.cnt = start ? waits : '0;
            end
         end
         default: begin
            n.st  = SL_IDLE;
            n.cnt = '0;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         r <= '{st: SL_IDLE, cnt: '0};
      end else begin
         r <= n;
      end
   end
endmodule : mbf_slot

// ---- hw/mbf_fabric.sv ----
/*
 mbf_fabric: memory-bus fabric between the CPU's program, data-read and
 data-write buses, one memory port and the peripheral bridge bus.
 assumes requests come from same-clock CPU logic and stay stable until
 their ack pulse; wait and protection settings are static while busy.
*/
// Contract
// - protected zone: write goes on the bus before a read, with stalls to align
// - outside protected zones a read may overtake an earlier pending write
// - protection selectable per frame, on by default for frames one and two
// - scratch, lower, upper RAM and frame zero zero-wait; boot ROM one wait
// - frames one and two: writes zero-wait, reads two; frame-one write pairs +1
// - frame-one slave may stretch an access; fabric holds until it is ready
// - OTP uses programmed wait count, never below one
// - flash array uses programmed wait count, zero allowed
// - flash password words always take sixteen waits
// - program bus: 22 address bits, 32 data bits
// - data read and write buses: 32 address and 32 data bits
// - fetch, data read and data write run together on separate targets; the fabric has two targets, so at most two run at once
// - per target priority: writes, data reads, program reads, fetches
// - data write and program write never issued in one cycle
// - program read and fetch never issued in one cycle
// - bridge muxes onto one bus: 16 address bits, 16/32 data bits
// - frame two takes 16-bit accesses only
// - frame one takes 16-bit and 32-bit accesses
// - peripheral frames reachable from data space only
`timescale 1ns/10ps
module mbf_fabric #(
   parameter int WS_W = mbf_pkg::WS_W
) (
   // clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     resetn,
   // program bus
   input  wire mbf_pkg::mbf_pgreq_t      pg_req,
   output logic                          pg_ack,
   output logic [mbf_pkg::DB_W-1:0]      pg_rdata,
   // data read bus
   input  wire mbf_pkg::mbf_rdreq_t      rd_req,
   output logic                          rd_ack,
   output logic [mbf_pkg::DB_W-1:0]      rd_rdata,
   // data write bus
   input  wire mbf_pkg::mbf_wrreq_t      wr_req,
   output logic                          wr_ack,
   // wait-state and protection settings
   input  wire logic [WS_W-1:0]          flash_wait,
   input  wire logic [WS_W-1:0]          otp_wait,
   input  wire logic [1:0]               prot_off,
   // memory port
   output mbf_pkg::mbf_mem_t             mem_port,
   input  wire logic [mbf_pkg::DB_W-1:0] mem_rdata,
   // peripheral bridge bus
   output mbf_pkg::mbf_pbus_t            pb_port,
   input  wire logic [mbf_pkg::DB_W-1:0] pb_rdata,
   input  wire logic                     pb_ready
);
   typedef struct packed {
      mbf_pkg::mbf_mem_t                mem;
      mbf_pkg::mbf_pbus_t               pb;
      logic                             wr_ack;
      logic                             rd_ack;
      logic                             pg_ack;
      logic [mbf_pkg::DB_W-1:0]         rd_data;
      logic [mbf_pkg::DB_W-1:0]         pg_data;
      logic                             wr_fl;
      logic                             rd_fl;
      logic                             pg_fl;
      logic                             rd_seen;
      logic                             wr_prot_fl;
      logic                             pf1_wr_prev;
      logic [1:0][2:0]                  src;
      logic [1:0][10:0]                 rg;
      logic [1:0]                       we;
   } mbf_fab_st_t;

   mbf_fab_st_t r;
   mbf_fab_st_t n;

   // decode and target selection
   mbf_pkg::mbf_region_t rg_w;
   mbf_pkg::mbf_region_t rg_r;
   mbf_pkg::mbf_region_t rg_p;
   logic                 tg_w;
   logic                 tg_r;
   logic                 tg_p;
   logic                 el_w;
   logic                 el_r;
   logic                 el_p;
   logic                 rd_blk;

   // slot handshake
   logic [1:0]           slot_start;
   logic [1:0][WS_W-1:0] slot_ws;
   logic [1:0]           slot_hold;
   logic [1:0]           slot_done;
   logic [1:0]           slot_idle;

   function automatic logic is_per(input mbf_pkg::mbf_region_t rg);
      is_per = (rg == mbf_pkg::RG_PF1) || (rg == mbf_pkg::RG_PF2);
   endfunction : is_per

   // zero in prot_off leaves the frame protected
   function automatic logic is_prot(input mbf_pkg::mbf_region_t rg, input logic [1:0] off);
      is_prot = ((rg == mbf_pkg::RG_PF1) && !off[0]) || ((rg == mbf_pkg::RG_PF2) && !off[1]);
   endfunction : is_prot

   function automatic logic [WS_W-1:0] waits_of(input mbf_pkg::mbf_region_t rg,
                                                input logic                 we,
                                                input logic                 b2b,
                                                input logic [WS_W-1:0]      fws,
                                                input logic [WS_W-1:0]      ows);
      unique case (rg)
         mbf_pkg::RG_SCR,
         mbf_pkg::RG_LOW,
         mbf_pkg::RG_UPR,
         mbf_pkg::RG_PF0:   waits_of = mbf_pkg::WS_ZERO;
         mbf_pkg::RG_BROM:  waits_of = mbf_pkg::WS_BROM;
         mbf_pkg::RG_PF1:   waits_of = we ? (b2b ? mbf_pkg::WS_PF1_B2B : mbf_pkg::WS_ZERO)
                                          : mbf_pkg::WS_PF_RD;
         mbf_pkg::RG_PF2:   waits_of = we ? mbf_pkg::WS_ZERO : mbf_pkg::WS_PF_RD;
         mbf_pkg::RG_OTP:   waits_of = (ows < mbf_pkg::WS_OTP_MIN) ? mbf_pkg::WS_OTP_MIN : ows;
         mbf_pkg::RG_FLASH: waits_of = fws;
         mbf_pkg::RG_PWD:   waits_of = mbf_pkg::WS_PWD;
         default:           waits_of = mbf_pkg::WS_ZERO;
      endcase
   endfunction : waits_of

   // program bus widened to the common address width
   assign rg_w = mbf_pkg::mbf_decode(wr_req.addr, !wr_req.prog);
   assign rg_r = mbf_pkg::mbf_decode(rd_req.addr, 1'b1);
   assign rg_p = mbf_pkg::mbf_decode({10'h000, pg_req.addr}, 1'b0);

   assign tg_w = is_per(rg_w);
   assign tg_r = is_per(rg_r);
   assign tg_p = is_per(rg_p);

   // a bus is eligible once per request: not in flight, not in its ack cycle
   assign el_w = wr_req.valid && !r.wr_fl && !r.wr_ack;
   assign el_r = rd_req.valid && !r.rd_fl && !r.rd_ack;
   assign el_p = pg_req.valid && !r.pg_fl && !r.pg_ack;

   // protected read waits one aligning cycle and behind any protected write
   assign rd_blk = is_prot(rg_r, prot_off) &&
                   (!r.rd_seen || r.wr_prot_fl || (el_w && is_prot(rg_w, prot_off)));

   // only the frame-one slave may stretch
   assign slot_hold[mbf_pkg::TGT_MEM] = 1'b0;
   assign slot_hold[mbf_pkg::TGT_PER] = (r.rg[mbf_pkg::TGT_PER] == mbf_pkg::RG_PF1) && !pb_ready;

   generate
      for (genvar gi = 0; gi < 2; gi++) begin : g_slot
         mbf_slot #(
            .WS_W (WS_W)
         ) u_slot (
            .core_clk (core_clk),
            .resetn   (resetn),
            .start    (slot_start[gi]),
            .waits    (slot_ws[gi]),
            .hold     (slot_hold[gi]),
            .done     (slot_done[gi]),
            .idle     (slot_idle[gi])
         );
      end
   endgenerate

   always_comb begin
      logic                  gsel;
      mbf_pkg::mbf_src_t     gsrc;
      mbf_pkg::mbf_region_t  grg;
      logic [31:0]           ga;
      logic [mbf_pkg::DB_W-1:0] gd;
      logic [mbf_pkg::DB_W-1:0] cap;
      logic                  gwe;
      logic                  gwide;
      logic                  b2b;
      gsel       = 1'b0;
      gsrc       = mbf_pkg::SRC_WR;
      grg        = mbf_pkg::RG_NONE;
      ga         = '0;
      gd         = '0;
      cap        = '0;
      gwe        = 1'b0;
      gwide      = 1'b0;
      b2b        = 1'b0;
      n          = r;
      slot_start = '0;
      slot_ws    = '0;
      n.wr_ack   = 1'b0;
      n.rd_ack   = 1'b0;
      n.pg_ack   = 1'b0;
      n.pf1_wr_prev = r.wr_ack && r.pf1_wr_prev;
      n.rd_seen  = el_r;

      // completion: drop port strobe, answer the owning bus
      for (int t = 0; t < 2; t++) begin
         if (slot_done[t]) begin
            if (t == mbf_pkg::TGT_MEM) begin
               n.mem.valid = 1'b0;
               cap = (r.rg[t] == mbf_pkg::RG_NONE) ? '0 : mem_rdata;
            end else begin
               n.pb.valid = 1'b0;
               cap = (r.rg[t] == mbf_pkg::RG_PF2) ? {16'h0000, pb_rdata[15:0]} : pb_rdata;
            end
            unique case (r.src[t])
               mbf_pkg::SRC_WR: begin
                  n.wr_ack     = 1'b1;
                  n.wr_fl      = 1'b0;
                  n.wr_prot_fl = 1'b0;
                  n.pf1_wr_prev = (r.rg[t] == mbf_pkg::RG_PF1);
               end
               mbf_pkg::SRC_RD: begin
                  n.rd_ack  = 1'b1;
                  n.rd_fl   = 1'b0;
                  n.rd_data = cap;
               end
               mbf_pkg::SRC_PG: begin
                  n.pg_ack  = 1'b1;
                  n.pg_fl   = 1'b0;
                  n.pg_data = cap;
               end
               default: begin
                  n.wr_fl = r.wr_fl;
               end
            endcase
         end
      end

      // back-to-back frame-one writes: finishing now, or next request after the ack
      b2b = r.pf1_wr_prev ||
            (slot_done[mbf_pkg::TGT_PER] && r.we[mbf_pkg::TGT_PER] &&
             (r.rg[mbf_pkg::TGT_PER] == mbf_pkg::RG_PF1));

      // grant, one access per target, targets run in parallel
      for (int t = 0; t < 2; t++) begin
         gsel = 1'b0;
         if (slot_idle[t] || slot_done[t]) begin
            // single write bus and single program bus keep the pairs apart
            if (el_w && (tg_w == t[0])) begin
               gsel  = 1'b1;
               gsrc  = mbf_pkg::SRC_WR;
               grg   = rg_w;
               ga    = wr_req.addr;
               gd    = wr_req.data;
               gwe   = 1'b1;
               gwide = wr_req.wide;
            end else if (el_r && !rd_blk && (tg_r == t[0])) begin
               // unprotected read may pass a stalled write on another target
               gsel  = 1'b1;
               gsrc  = mbf_pkg::SRC_RD;
               grg   = rg_r;
               ga    = rd_req.addr;
               gd    = '0;
               gwe   = 1'b0;
               gwide = rd_req.wide;
            end else if (el_p && (tg_p == t[0])) begin
               gsel  = 1'b1;
               gsrc  = mbf_pkg::SRC_PG;
               grg   = rg_p;
               ga    = {10'h000, pg_req.addr};
               gd    = '0;
               gwe   = 1'b0;
               gwide = 1'b1;
            end
         end
         if (gsel) begin
            slot_start[t] = 1'b1;
            slot_ws[t]    = waits_of(grg, gwe, b2b, flash_wait, otp_wait);
            n.src[t]      = gsrc;
            n.rg[t]       = grg;
            n.we[t]       = gwe;
            unique case (gsrc)
               mbf_pkg::SRC_WR: begin
                  n.wr_fl      = 1'b1;
                  n.wr_prot_fl = is_prot(grg, prot_off);
               end
               mbf_pkg::SRC_RD: n.rd_fl = 1'b1;
               mbf_pkg::SRC_PG: n.pg_fl = 1'b1;
               default:         n.pg_fl = r.pg_fl;
            endcase
            if (t == mbf_pkg::TGT_MEM) begin
               // full 32-bit data path, one cycle per 32-bit op
               n.mem.valid = (grg != mbf_pkg::RG_NONE);
               n.mem.we    = gwe;
               n.mem.wide  = gwide;
               n.mem.addr  = ga[mbf_pkg::PAB_W-1:0];
               n.mem.wdata = gd;
            end else begin
               n.pb.valid = 1'b1;
               n.pb.we    = gwe;
               n.pb.wide  = gwide && (grg == mbf_pkg::RG_PF1);
               n.pb.addr  = ga[mbf_pkg::PB_AW-1:0];
               n.pb.wdata = (grg == mbf_pkg::RG_PF2) ? {16'h0000, gd[15:0]} : gd;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // all outputs straight from state
   assign pg_ack   = r.pg_ack;
   assign pg_rdata = r.pg_data;
   assign rd_ack   = r.rd_ack;
   assign rd_rdata = r.rd_data;
   assign wr_ack   = r.wr_ack;
   assign mem_port = r.mem;
   assign pb_port  = r.pb;
endmodule : mbf_fabric

// ---- verif/mbf_fabric_props.sv ----
/*
 mbf_fabric_props: port-level checks on the memory-bus fabric.
 assumes word addresses on both target ports, bound to every mbf_fabric.
*/
`timescale 1ns/10ps
module mbf_fabric_props #(
   parameter int WS_W = mbf_pkg::WS_W
) (
   // clock and reset
   input wire logic                     core_clk,
   input wire logic                     resetn,
   // cpu buses
   input wire mbf_pkg::mbf_pgreq_t      pg_req,
   input wire logic                     pg_ack,
   input wire logic [mbf_pkg::DB_W-1:0] pg_rdata,
   input wire mbf_pkg::mbf_rdreq_t      rd_req,
   input wire logic                     rd_ack,
   input wire logic [mbf_pkg::DB_W-1:0] rd_rdata,
   input wire mbf_pkg::mbf_wrreq_t      wr_req,
   input wire logic                     wr_ack,
   // settings
   input wire logic [WS_W-1:0]          flash_wait,
   input wire logic [WS_W-1:0]          otp_wait,
   input wire logic [1:0]               prot_off,
   // targets
   input wire mbf_pkg::mbf_mem_t        mem_port,
   input wire logic [mbf_pkg::DB_W-1:0] mem_rdata,
   input wire mbf_pkg::mbf_pbus_t       pb_port,
   input wire logic [mbf_pkg::DB_W-1:0] pb_rdata,
   input wire logic                     pb_ready
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);

   chk_pwd_waits: assert property ($rose(mem_port.valid) && mem_port.addr[21:3] == 19'h7EFFF
      |-> mem_port.valid[*8] ##1 mem_port.valid[*8] ##1 mem_port.valid ##1 !mem_port.valid)
      else $error("password access not sixteen waits");
   chk_brom_wait: assert property ($rose(mem_port.valid) && mem_port.addr[21:12] == 10'h3FF
      |-> mem_port.valid ##1 mem_port.valid ##1 !mem_port.valid)
      else $error("boot rom access not one wait");
   chk_pf_rd_waits: assert property ($rose(pb_port.valid) && !pb_port.we |-> pb_port.valid[*3])
      else $error("frame read shorter than two waits");
   chk_pf2_narrow: assert property (pb_port.valid && pb_port.addr[15:12] == 4'h7 |-> !pb_port.wide)
      else $error("wide access on frame two");
   chk_stretch_hold: assert property (pb_port.valid && !pb_ready && pb_port.addr[15:12] == 4'h6
      |=> pb_port.valid && $stable(pb_port.addr))
      else $error("frame one access dropped while slave not ready");
   chk_pb_data_src: assert property ($rose(pb_port.valid)
      |-> $past(rd_req.valid || (wr_req.valid && !wr_req.prog)))
      else $error("peripheral strobe without data-space request");
   chk_rd_ack_pulse: assert property (rd_ack |=> !rd_ack)
      else $error("read ack longer than one cycle");
   chk_wr_ack_pulse: assert property (wr_ack |=> !wr_ack)
      else $error("write ack longer than one cycle");

   cover property (pb_port.valid && !pb_ready);
   cover property (mem_port.valid && pb_port.valid);
   cover property (pg_ack);
endmodule : mbf_fabric_props

bind mbf_fabric mbf_fabric_props #(.WS_W(WS_W)) u_props (.core_clk(core_clk), .resetn(resetn),
   .pg_req(pg_req), .pg_ack(pg_ack), .pg_rdata(pg_rdata), .rd_req(rd_req), .rd_ack(rd_ack),
   .rd_rdata(rd_rdata), .wr_req(wr_req), .wr_ack(wr_ack), .flash_wait(flash_wait), .otp_wait(otp_wait),
   .prot_off(prot_off), .mem_port(mem_port), .mem_rdata(mem_rdata), .pb_port(pb_port),
   .pb_rdata(pb_rdata), .pb_ready(pb_ready));

// ---- verif/mbf_tgt_model.sv ----
/*
 mbf_tgt_model: memory and peripheral targets behind the fabric.
 assumes data sampled in the last valid cycle; stretch set by the bench.
*/
`timescale 1ns/10ps
module mbf_tgt_model (
   // clock
   input wire logic               core_clk,
   // target ports
   input wire mbf_pkg::mbf_mem_t  mem_port,
   input wire mbf_pkg::mbf_pbus_t pb_port,
   input wire logic [3:0]         stretch,
   // answers
   output logic [31:0]            mem_rdata,
   output logic [31:0]            pb_rdata,
   output logic                   pb_ready
);
   logic [31:0] noise_r = 32'h0;
   logic [3:0]  held_r  = 4'h0;

   // idle data lines keep moving so stale values never match
   always_ff @(posedge core_clk) begin
      noise_r <= ~noise_r ^ 32'h1357_9BDF;
      held_r  <= pb_port.valid ? held_r + 4'h1 : 4'h0;
   end
   assign mem_rdata = mem_port.valid ? ({10'h000, mem_port.addr} ^ 32'hA5A5_0000) : noise_r;
   assign pb_rdata  = pb_port.valid ? {16'h5A5A, pb_port.addr} : noise_r;
   // frame-one slave holds ready low for its first stretch cycles
   assign pb_ready  = !(pb_port.valid && pb_port.addr[15:12] == 4'h6 && held_r < stretch);
endmodule : mbf_tgt_model

// ---- verif/memory_bus_fabric_wait_states_tb_top.sv ----
/*
 bench for mbf_fabric: cpu buses driven here, targets from mbf_tgt_model.
 assumes the fabric timing of a grant edge, strobe next, ack after waits.
*/
`timescale 1ns/10ps
module memory_bus_fabric_wait_states_tb_top;
   logic                core_clk, resetn, pg_ack, rd_ack, wr_ack, pb_ready, first_we, pb_seen;
   mbf_pkg::mbf_pgreq_t pg_req;
   mbf_pkg::mbf_rdreq_t rd_req;
   mbf_pkg::mbf_wrreq_t wr_req;
   mbf_pkg::mbf_mem_t   mem_port;
   mbf_pkg::mbf_pbus_t  pb_port;
   logic [31:0]         pg_rdata, rd_rdata, mem_rdata, pb_rdata;
   logic [4:0]          flash_wait, otp_wait;
   logic [1:0]          prot_off;
   logic [3:0]          stretch;
   int                  fail_count, checks_done, pb_cnt;

   mbf_fabric #(.WS_W(mbf_pkg::WS_W)) DUT (.core_clk(core_clk), .resetn(resetn), .pg_req(pg_req),
      .pg_ack(pg_ack), .pg_rdata(pg_rdata), .rd_req(rd_req), .rd_ack(rd_ack), .rd_rdata(rd_rdata),
      .wr_req(wr_req), .wr_ack(wr_ack), .flash_wait(flash_wait), .otp_wait(otp_wait), .prot_off(prot_off),
      .mem_port(mem_port), .mem_rdata(mem_rdata), .pb_port(pb_port), .pb_rdata(pb_rdata), .pb_ready(pb_ready));
   mbf_tgt_model u_tgt (.core_clk(core_clk), .mem_port(mem_port), .pb_port(pb_port), .stretch(stretch),
      .mem_rdata(mem_rdata), .pb_rdata(pb_rdata), .pb_ready(pb_ready));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      if (pb_port.valid) begin
         pb_cnt <= pb_cnt + 1;
         if (!pb_seen) begin
            pb_seen  <= 1'b1;
            first_we <= pb_port.we;
         end
      end
   end

   function automatic logic [31:0] memx(input logic [31:0] a);
      return {10'h000, a[21:0]} ^ 32'hA5A5_0000;
   endfunction : memx

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic conclude;
      if (fail_count == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude

   // bus 0 fetch, 1 data read, 2 data write; exp_n counts edges after launch, 0 skips it
   task automatic xfer(input int bus, input logic [31:0] a, input logic w, input int exp_n, input logic [31:0] d);
      int   n;
      logic ack;
      @(posedge core_clk);
      case (bus)
         0: pg_req <= '{1'b1, 1'b1, a[21:0]};
         1: rd_req <= '{1'b1, w, a};
         default: wr_req <= '{1'b1, 1'b0, w, a, d};
      endcase
      n   = 0;
      ack = 1'b0;
      while (ack !== 1'b1 && n < 40) begin
         @(posedge core_clk);
         #1;
         n++;
         ack = (bus == 0) ? pg_ack : (bus == 1) ? rd_ack : wr_ack;
      end
      if (exp_n != 0) check(n, exp_n);
      if (bus != 2) check((bus == 0) ? pg_rdata : rd_rdata, d);
      @(posedge core_clk);
      case (bus)
         0: pg_req.valid <= 1'b0;
         1: rd_req.valid <= 1'b0;
         default: wr_req.valid <= 1'b0;
      endcase
   endtask : xfer

   task automatic t_waits;
      logic [31:0] ta [10] = '{32'h10, 32'h810, 32'h8010, 32'hA010, 32'h3FF010, 32'h3D7810, 32'h3D8010,
                               32'h3F7FF8, 32'h3D7820, 32'h3E0010};
      int          fw [10] = '{0, 0, 0, 0, 0, 3, 3, 3, 0, 0};
      int          ow [10] = '{0, 0, 0, 0, 0, 0, 0, 0, 4, 0};
      int          tw [10] = '{0, 0, 0, 0, 1, 1, 3, 16, 4, 0};
      for (int i = 0; i < 10; i++) begin
         @(posedge core_clk);
         flash_wait <= fw[i][4:0];
         otp_wait   <= ow[i][4:0];
         xfer(1, ta[i], 1'b1, tw[i] + 2, memx(ta[i]));
      end
   endtask : t_waits

   task automatic t_frames;
      xfer(1, 32'h7010, 1'b0, 5, 32'h0000_7010);
      @(posedge core_clk);
      prot_off <= 2'b11;
      xfer(1, 32'h7010, 1'b0, 4, 32'h0000_7010);
      xfer(1, 32'h6010, 1'b1, 4, 32'h5A5A_6010);
      xfer(2, 32'h7020, 1'b0, 2, 32'h0000_1234);
      xfer(2, 32'h6020, 1'b1, 2, 32'h89AB_CDEF);
      @(posedge core_clk);
      prot_off <= 2'b00;
      pb_seen = 1'b0;
      fork xfer(2, 32'h6030, 1'b1, 2, 32'h1); xfer(1, 32'h7030, 1'b0, 0, 32'h7030); join
      check(first_we, 1'b1);
   endtask : t_frames

   task automatic t_pair;
      int n;
      @(posedge core_clk);
      wr_req <= '{1'b1, 1'b0, 1'b0, 32'h6040, 32'h11};
      repeat (2) @(posedge core_clk);
      #1;
      check(wr_ack, 1'b1);
      @(posedge core_clk);
      wr_req <= '{1'b1, 1'b0, 1'b0, 32'h6042, 32'h22};
      n = 0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (wr_ack !== 1'b1 && n < 40);
      check(n, 3);
      @(posedge core_clk);
      wr_req.valid <= 1'b0;
      @(posedge core_clk);
      stretch <= 4'h3;
      xfer(2, 32'h6050, 1'b1, 5, 32'h5);
      @(posedge core_clk);
      stretch <= 4'h0;
   endtask : t_pair

   task automatic t_prio;
      int c0;
      fork xfer(1, 32'h20, 1'b1, 2, memx(32'h20)); xfer(0, 32'h24, 1'b1, 3, memx(32'h24)); join
      fork xfer(2, 32'h8020, 1'b1, 2, 32'h7); xfer(1, 32'h8024, 1'b1, 3, memx(32'h8024)); join
      fork xfer(0, 32'h3E0000, 1'b1, 2, memx(32'h3E0000)); xfer(1, 32'h7040, 1'b0, 5, 32'h7040); join
      c0 = pb_cnt;
      xfer(0, 32'h6010, 1'b1, 0, 32'h0);
      check(pb_cnt - c0, 0);
   endtask : t_prio

   initial begin
      pg_req      = '0;
      rd_req      = '0;
      wr_req      = '0;
      flash_wait  = '0;
      otp_wait    = '0;
      prot_off    = '0;
      stretch     = '0;
      resetn      = 1'b0;
      fail_count  = 0;
      checks_done = 0;
      pb_cnt      = 0;
      pb_seen     = 1'b1;
      first_we    = 1'b0;
      repeat (4) @(posedge core_clk);
      resetn <= 1'b1;
      t_waits();
      t_frames();
      t_pair();
      t_prio();
      conclude();
   end

   initial begin
      #20000;
      fail_count++;
      conclude();
   end
endmodule : memory_bus_fabric_wait_states_tb_top
